// ### src/ssps_pkg.sv
package ssps_pkg;
	// ---------------------------------------------------------------
	// timing at 40 mhz
	// ---------------------------------------------------------------
	localparam int CLK_HZ          = 40000000;
	localparam real SOFT_START_MS  = 3.5;
	localparam real BROWNOUT_MS    = 32.0;
	localparam real OVERPOWER_MS   = 27.5;
	localparam int SOFT_START_CYC  = int'(SOFT_START_MS * CLK_HZ / 1000.0);
	localparam int BROWNOUT_CYC    = int'(BROWNOUT_MS * CLK_HZ / 1000.0);
	localparam int OVERPOWER_CYC   = int'(OVERPOWER_MS * CLK_HZ / 1000.0);
	// ---------------------------------------------------------------
	// counts and widths
	// ---------------------------------------------------------------
	localparam int OPP_RESTARTS    = 3;
	localparam int MAXDUTY_STROKES = 8;
	localparam int LIMIT_W         = 8;
	localparam int TIMER_W         = 24;
	localparam logic [7:0] LIMIT_RST = 8'h00;

	typedef enum {
		SSPS_OFF,
		SSPS_CHECK,
		SSPS_RUN,
		SSPS_DISCHARGE,
		SSPS_RECHARGE,
		SSPS_LATCHED
	} ssps_state_e;
endpackage

// ### src/ssps_timer_if.sv
`timescale 1ns/1ps
interface ssps_timer_if #(parameter int W = 24);
	logic         ce;
	logic         run;
	logic [W-1:0] limit;
	logic         done;
	modport ctl (output ce, output run, output limit, input done);
	modport tmr (input ce, input run, input limit, output done);
endinterface

// ### src/ssps_timer.sv
`timescale 1ns/1ps
module ssps_timer #(parameter int W = 24) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// control
	ssps_timer_if.tmr t
);
	logic [W-1:0] cnt_q;
	logic         done_q;
	wire          hit = (cnt_q >= t.limit);
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_q  <= '0;
			done_q <= 1'b0;
		end else if (t.ce) begin
			if (!t.run) begin
				cnt_q  <= '0;
				done_q <= 1'b0;
			end else if (!hit) begin
				cnt_q <= cnt_q + 1'b1;
			end else begin
				done_q <= 1'b1;
			end
		end
	end
	assign t.done = done_q;
endmodule // ssps_timer

// ### src/ssps_seq.sv
`timescale 1ns/1ps
// Notes on behaviour
// - below start-up threshold: stay low power, gate never driven
// - at start-up threshold, check mains and sense input first
// - switch only if brownin seen and sense above detect threshold
// - peak current limit ramps up over 3.5 ms soft start
// - any protection stops gate at once, then restart or latch
// - overpower, lockout, brownout, max duty faults restart
// - overvoltage and overtemperature faults latch off
// - restart: wait lockout, power down, recharge to start-up, resume
// - overpower repeats discharge and recharge three times
// - latched fault: power down now, clamp supply above latch reset
// - lockout in run: stop, wait for start-up threshold
// - brownout only after mains low continuously 32 ms
// - eight consecutive max duty strokes trigger restart
// - overload lasting over 27.5 ms raises overpower fault
module ssps_seq #(
	parameter int BROWNOUT_CYCLES  = ssps_pkg::BROWNOUT_CYC,
	parameter int OVERPOWER_CYCLES = ssps_pkg::OVERPOWER_CYC,
	parameter int SOFT_CYCLES      = ssps_pkg::SOFT_START_CYC,
	parameter int RESTARTS         = ssps_pkg::OPP_RESTARTS,
	parameter int STROKES          = ssps_pkg::MAXDUTY_STROKES
) (
	// clock, reset, enable
	input  wire logic                        clk,
	input  wire logic                        rst_n,
	input  wire logic                        ce,
	// supply comparators
	input  wire logic                        supply_at_startup,
	input  wire logic                        supply_below_lockout,
	input  wire logic                        supply_below_latch_reset,
	// start-up check results
	input  wire logic                        mains_above_turn_on_level,
	input  wire logic                        sense_above_detect,
	input  wire logic                        check_done,
	// run-time indications
	input  wire logic                        mains_below_brownout,
	input  wire logic                        overload,
	input  wire logic                        stroke_end,
	input  wire logic                        stroke_at_max_duty,
	input  wire logic                        latch_fault,
	input  wire logic                        gate_request,
	// outputs
	output logic                             gate_out,
	output logic                             low_power,
	output logic                             check_active,
	output logic                             supply_clamp,
	output logic                             overpower_fault,
	output logic [ssps_pkg::LIMIT_W-1:0]     current_sense_limit
);
	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	ssps_pkg::ssps_state_e state_q, state_d;
	logic [1:0]  restarts_q;
	logic [3:0]  strokes_q;
	logic        opp_mode_q;
	logic [ssps_pkg::TIMER_W-1:0] bo_q, soft_q;
	logic [ssps_pkg::LIMIT_W-1:0] lim_q;

	ssps_timer_if #(.W(ssps_pkg::TIMER_W)) opp_t ();
	ssps_timer u_opp (
		.clk   (clk),
		.rst_n (rst_n),
		.t     (opp_t.tmr)
	);

	wire running = (state_q == ssps_pkg::SSPS_RUN);
	assign opp_t.ce    = ce;
	assign opp_t.run   = running && overload;
	assign opp_t.limit = ssps_pkg::TIMER_W'(OVERPOWER_CYCLES);

	// ---------------------------------------------------------------
	// fault decoding
	// ---------------------------------------------------------------
	wire opp_hit      = opp_t.done;
	wire brownout_hit = (bo_q >= ssps_pkg::TIMER_W'(BROWNOUT_CYCLES));
	wire maxduty_hit  = stroke_end && stroke_at_max_duty &&
	                    (strokes_q == 4'(STROKES - 1));
	wire restart_hit  = opp_hit || brownout_hit || maxduty_hit
	                    || supply_below_lockout;
	wire qualified    = mains_above_turn_on_level && sense_above_detect;

	always_comb begin
		state_d = state_q;
		case (state_q)
			ssps_pkg::SSPS_OFF: begin
				if (supply_at_startup)
					state_d = ssps_pkg::SSPS_CHECK;
			end
			ssps_pkg::SSPS_CHECK: begin
				if (supply_below_lockout)
					state_d = ssps_pkg::SSPS_OFF;
				else if (check_done && qualified)
					state_d = ssps_pkg::SSPS_RUN;
			end
			ssps_pkg::SSPS_RUN: begin
				if (latch_fault)
					state_d = ssps_pkg::SSPS_LATCHED;
				else if (restart_hit)
					state_d = ssps_pkg::SSPS_DISCHARGE;
			end
			ssps_pkg::SSPS_DISCHARGE: begin
				if (supply_below_lockout)
					state_d = ssps_pkg::SSPS_RECHARGE;
			end
			ssps_pkg::SSPS_RECHARGE: begin
				if (supply_at_startup) begin
					if (opp_mode_q && restarts_q != 2'(RESTARTS - 1))
						state_d = ssps_pkg::SSPS_DISCHARGE;
					else
						state_d = ssps_pkg::SSPS_CHECK;
				end
			end
			ssps_pkg::SSPS_LATCHED: begin
				if (supply_below_latch_reset)
					state_d = ssps_pkg::SSPS_OFF;
			end
			default: state_d = ssps_pkg::SSPS_OFF;
		endcase
	end

	// ---------------------------------------------------------------
	// soft start ramp: limit steps once per slice of the interval
	// ---------------------------------------------------------------
	localparam int STEP_CYC = (SOFT_CYCLES >> ssps_pkg::LIMIT_W) > 0 ?
	                          (SOFT_CYCLES >> ssps_pkg::LIMIT_W) : 1;
	wire soft_tick = (soft_q >= ssps_pkg::TIMER_W'(STEP_CYC - 1));

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic at_ceiling(input logic [ssps_pkg::LIMIT_W-1:0] v);
		return v == '1;
	endfunction

	// power-down states: supply only charges through the start-up path
	function automatic logic is_quiet(input ssps_pkg::ssps_state_e s);
		return s == ssps_pkg::SSPS_OFF || s == ssps_pkg::SSPS_RECHARGE || s == ssps_pkg::SSPS_LATCHED;
	endfunction

	// ---------------------------------------------------------------
	// supervisor counters: next values
	// ---------------------------------------------------------------
	wire                          mains_low_run = running && mains_below_brownout;
	wire                          restart_entry = running && restart_hit && !latch_fault;
	wire                          recharge_done = (state_q == ssps_pkg::SSPS_RECHARGE) && supply_at_startup;

	logic [ssps_pkg::TIMER_W-1:0] bo_d;
	logic [ssps_pkg::TIMER_W-1:0] soft_d;
	logic [3:0]                   strokes_d;
	logic [1:0]                   restarts_d;
	logic                         opp_mode_d;
	logic [ssps_pkg::LIMIT_W-1:0] lim_d;

	// brownout only counts while mains low without a break
	assign bo_d       = !mains_low_run ? '0 : brownout_hit ? bo_q : bo_q + 1'b1;
	// a normal stroke breaks the run of max-duty strokes
	assign strokes_d  = !running ? 4'h0 :
	                    !stroke_end ? strokes_q :
	                    stroke_at_max_duty ? strokes_q + 4'h1 : 4'h0;
	// overpower mode is decided once, at the moment switching stops
	assign opp_mode_d = restart_entry ? opp_hit : opp_mode_q;
	assign restarts_d = restart_entry ? 2'h0 :
	                    recharge_done ? restarts_q + 2'h1 : restarts_q;

	// ---------------------------------------------------------------
	// soft start ramp: next values
	// ---------------------------------------------------------------
	// ramp restarts from zero on every start
	assign soft_d     = !running ? '0 : at_ceiling(lim_q) ? soft_q :
	                    soft_tick ? '0 : soft_q + 1'b1;
	assign lim_d      = !running ? ssps_pkg::LIMIT_RST :
	                    (!at_ceiling(lim_q) && soft_tick) ? lim_q + 1'b1 : lim_q;

	// ---------------------------------------------------------------
	// state registers
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_q <= ssps_pkg::SSPS_OFF;
		end else if (ce) begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			bo_q <= '0;
		end else if (ce) begin
			bo_q <= bo_d;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			strokes_q <= 4'h0;
		end else if (ce) begin
			strokes_q <= strokes_d;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			opp_mode_q <= 1'b0;
		end else if (ce) begin
			opp_mode_q <= opp_mode_d;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			restarts_q <= 2'h0;
		end else if (ce) begin
			restarts_q <= restarts_d;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			soft_q <= '0;
		end else if (ce) begin
			soft_q <= soft_d;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			lim_q <= ssps_pkg::LIMIT_RST;
		end else if (ce) begin
			lim_q <= lim_d;
		end
	end

	// ---------------------------------------------------------------
	// registered outputs
	// ---------------------------------------------------------------
	// gate needs both the present and next state in run, so it drops on the fault edge
	wire                          gate_out_d     = (state_d == ssps_pkg::SSPS_RUN) && running && gate_request;
	wire                          low_power_d    = is_quiet(state_d);
	wire                          check_active_d = state_d == ssps_pkg::SSPS_CHECK;
	wire                          supply_clamp_d = state_d == ssps_pkg::SSPS_LATCHED;
	wire                          opp_set        = running && opp_hit;
	wire                          opp_keep       = overpower_fault && !running;
	wire                          opp_clear      = state_d == ssps_pkg::SSPS_CHECK;
	wire                          opp_fault_d    = opp_set || (opp_keep && !opp_clear);
	wire [ssps_pkg::LIMIT_W-1:0]  limit_d        = running ? lim_q : ssps_pkg::LIMIT_RST;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			gate_out <= 1'b0;
		end else if (ce) begin
			gate_out <= gate_out_d;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			low_power <= 1'b1;
		end else if (ce) begin
			low_power <= low_power_d;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			check_active <= 1'b0;
		end else if (ce) begin
			check_active <= check_active_d;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			supply_clamp <= 1'b0;
		end else if (ce) begin
			supply_clamp <= supply_clamp_d;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			overpower_fault <= 1'b0;
		end else if (ce) begin
			overpower_fault <= opp_fault_d;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			current_sense_limit <= ssps_pkg::LIMIT_RST;
		end else if (ce) begin
			current_sense_limit <= limit_d;
		end
	end
endmodule // ssps_seq

// ### dv/ssps_seq_monitor.sv
`timescale 1ns/1ps
module ssps_seq_monitor (
	// watched ports
	input wire logic                        clk,
	input wire logic                        rst_n,
	input wire logic                        supply_at_startup,
	input wire logic                        supply_below_lockout,
	input wire logic                        supply_below_latch_reset,
	input wire logic                        mains_above_turn_on_level,
	input wire logic                        check_done,
	input wire logic                        mains_below_brownout,
	input wire logic                        overload,
	input wire logic                        latch_fault,
	input wire logic                        gate_request,
	input wire logic                        gate_out,
	input wire logic                        low_power,
	input wire logic                        check_active,
	input wire logic                        supply_clamp,
	input wire logic                        overpower_fault,
	input wire logic [ssps_pkg::LIMIT_W-1:0] current_sense_limit
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	chk_idle_no_gate: assert property (low_power |-> !gate_out) else $error("gate on in low power");
	chk_check_startup: assert property ($rose(check_active) |-> $past(supply_at_startup)) else $error("early check");
	chk_check_fail: assert property (check_active && check_done && !mains_above_turn_on_level |=> !gate_out [*2])
		else $error("gate after failed check");
	chk_soft_start: assert property ($rose(gate_out) |-> current_sense_limit < 8'h10) else $error("no ramp");
	chk_latch_stop: assert property (latch_fault |=> !gate_out) else $error("gate kept on fault");
	chk_latch_clamp: assert property (latch_fault && gate_out |-> ##[1:2] (supply_clamp && low_power))
		else $error("no clamp");
	chk_clamp_hold: assert property (supply_clamp && !supply_below_latch_reset |=> supply_clamp)
		else $error("latch lost");
	chk_lockout_stop: assert property (gate_out && supply_below_lockout |=> !gate_out) else $error("gate in lockout");
	chk_opp_trip: assert property ($rose(overpower_fault) |-> $past(overload) && !gate_out) else $error("bad trip");
	chk_brownout_wait: assert property ($rose(mains_below_brownout) && gate_out && gate_request && !overload
		&& !latch_fault && !supply_below_lockout |=> gate_out) else $error("early brownout");
endmodule // ssps_seq_monitor
bind ssps_seq ssps_seq_monitor ssps_seq_monitor_inst (.clk(clk), .rst_n(rst_n), .supply_at_startup(supply_at_startup),
	.supply_below_lockout(supply_below_lockout), .supply_below_latch_reset(supply_below_latch_reset),
	.mains_above_turn_on_level(mains_above_turn_on_level), .check_done(check_done), .overload(overload),
	.mains_below_brownout(mains_below_brownout), .latch_fault(latch_fault), .gate_request(gate_request),
	.gate_out(gate_out), .low_power(low_power), .check_active(check_active), .supply_clamp(supply_clamp),
	.overpower_fault(overpower_fault), .current_sense_limit(current_sense_limit));

// ### dv/ssps_supply_model.sv
`timescale 1ns/1ps
module ssps_supply_model (
	// controller side
	input wire logic clk,
	input wire logic low_power,
	input wire logic check_active,
	input wire logic gate_out,
	input wire logic supply_clamp,
	// scenario controls
	input wire logic drain,
	input wire logic ok,
	// comparators
	output logic     supply_at_startup,
	output logic     supply_below_lockout,
	output logic     supply_below_latch_reset,
	output logic     check_done,
	output logic     mains_above_turn_on_level,
	output logic     sense_above_detect
);
	int vcc = 0;
	int cnt = 0;
	assign supply_at_startup = vcc >= 100;
	assign supply_below_lockout = vcc < 40;
	assign supply_below_latch_reset = vcc < 20;
	assign mains_above_turn_on_level = ok;
	assign sense_above_detect = ok;
	assign check_done = check_active && cnt == 3;
	// no aux winding: supply only holds while gate switches
	always @(posedge clk) begin
		cnt <= check_active ? (cnt + 1) % 4 : 0;
		if (drain) vcc <= vcc > 0 ? vcc - 1 : 0;
		else if (supply_clamp) vcc <= 30;
		else if (low_power) vcc <= vcc < 100 ? vcc + 1 : 100;
		else if (!gate_out && vcc > 0) vcc <= vcc - 1;
	end
endmodule // ssps_supply_model

// ### dv/smps_startup_protection_sequencer_tb_top.sv
`timescale 1ns/1ps
module smps_startup_protection_sequencer_tb_top;
	logic clk = 1'b0, rst_n = 1'b0, drain = 1'b0, ok = 1'b1, mains_below_brownout = 1'b0, overload = 1'b0;
	logic stroke_end = 1'b0, stroke_at_max_duty = 1'b0, latch_fault = 1'b0, lp;
	logic supply_at_startup, supply_below_lockout, supply_below_latch_reset, check_done, mains_ok, sense_ok;
	logic gate_out, low_power, check_active, supply_clamp, overpower_fault;
	logic [ssps_pkg::LIMIT_W-1:0] current_sense_limit;
	int   fails = 0, samples_checked = 0, cycles = 0, rises;
	always #12.5 clk = ~clk;
	ssps_seq #(.BROWNOUT_CYCLES(40), .OVERPOWER_CYCLES(40), .SOFT_CYCLES(512)) ssps_seq_inst (.clk(clk),
		.rst_n(rst_n), .ce(1'b1), .supply_at_startup(supply_at_startup), .supply_below_lockout(supply_below_lockout),
		.supply_below_latch_reset(supply_below_latch_reset), .mains_above_turn_on_level(mains_ok),
		.sense_above_detect(sense_ok), .check_done(check_done), .mains_below_brownout(mains_below_brownout),
		.overload(overload), .stroke_end(stroke_end), .stroke_at_max_duty(stroke_at_max_duty),
		.latch_fault(latch_fault), .gate_request(1'b1), .gate_out(gate_out), .low_power(low_power),
		.check_active(check_active), .supply_clamp(supply_clamp), .overpower_fault(overpower_fault),
		.current_sense_limit(current_sense_limit));
	ssps_supply_model ssps_supply_model_inst (.clk(clk), .low_power(low_power), .check_active(check_active),
		.gate_out(gate_out), .supply_clamp(supply_clamp), .drain(drain), .ok(ok), .check_done(check_done),
		.supply_at_startup(supply_at_startup), .supply_below_lockout(supply_below_lockout),
		.supply_below_latch_reset(supply_below_latch_reset), .mains_above_turn_on_level(mains_ok),
		.sense_above_detect(sense_ok));
	task automatic check_bit(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %0t flag %b expected %b", $time, got, exp);
		end
	endtask
	task automatic check_num(input int got, input int exp);
		samples_checked++;
		if (got != exp) begin
			fails++;
			$display("MISMATCH %0t count %0d expected %0d", $time, got, exp);
		end
	endtask
	// counts power-down entries on the way
	task automatic wait_gate(input logic e, input int lim);
		rises = 0;
		lp = low_power;
		for (int i = 0; i < lim && gate_out !== e; i++) begin
			@(negedge clk);
			if (low_power && !lp) rises++;
			lp = low_power;
		end
		check_bit(gate_out, e);
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			complete_run;
		end
	end
	initial begin
		void'($urandom(32'hd2f7));
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk) check_bit(low_power, 1'b1);
		wait_gate(1'b1, 400);
		check_bit(current_sense_limit < 8'h20, 1'b1);
		repeat (600) @(negedge clk);
		check_bit(current_sense_limit === 8'hff, 1'b1);
		$display("startup done");
		@(posedge clk) overload <= 1'b1;
		repeat ($urandom % 30 + 1) @(posedge clk);
		overload <= 1'b0;
		@(negedge clk) check_bit(overpower_fault, 1'b0);
		@(posedge clk) overload <= 1'b1;
		wait_gate(1'b0, 60);
		check_bit(overpower_fault, 1'b1);
		@(posedge clk) overload <= 1'b0;
		wait_gate(1'b1, 2000);
		check_num(rises, 3);
		$display("overpower done");
		for (int n = 0; n < 16; n++) begin
			@(posedge clk) stroke_end <= 1'b1;
			stroke_at_max_duty <= (n != 7);
			@(posedge clk) stroke_end <= 1'b0;
			if (n == 14) @(negedge clk) check_bit(gate_out, 1'b1);
		end
		wait_gate(1'b0, 4);
		wait_gate(1'b1, 1000);
		check_num(rises, 1);
		$display("max duty done");
		for (int len = 30; len <= 50; len += 20) begin
			@(posedge clk) mains_below_brownout <= 1'b1;
			repeat (len) @(posedge clk);
			mains_below_brownout <= 1'b0;
			@(negedge clk) check_bit(gate_out, len < 40);
		end
		wait_gate(1'b1, 1000);
		check_num(rises, 1);
		$display("brownout done");
		@(posedge clk) drain <= 1'b1;
		wait_gate(1'b0, 100);
		@(posedge clk) drain <= 1'b0;
		wait_gate(1'b1, 1000);
		$display("lockout done");
		@(posedge clk) latch_fault <= 1'b1;
		repeat (2) @(negedge clk);
		check_bit(gate_out, 1'b0);
		@(posedge clk) latch_fault <= 1'b0;
		repeat (200) @(negedge clk);
		check_bit(supply_clamp, 1'b1);
		check_bit(gate_out, 1'b0);
		@(posedge clk) drain <= 1'b1;
		ok <= 1'b0;
		repeat (20) @(posedge clk);
		drain <= 1'b0;
		repeat (400) @(negedge clk);
		check_bit(gate_out, 1'b0);
		@(posedge clk) ok <= 1'b1;
		wait_gate(1'b1, 400);
		$display("latch done");
		complete_run;
	end
endmodule // smps_startup_protection_sequencer_tb_top
